// ==== bench/l4m_parser_model.sv ====
// parser stand-in: presents one parsed frame header per call of send
// assumes: send is called just after a rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module l4m_parser_model
(
   input  wire logic        pclk,
   output logic             frm_valid,
   output logic             frm_is_tcp,
   output logic             frm_is_icmp,
   output logic [15:0]      frm_dport,
   output logic [5:0]       frm_tcp_flags,
   output logic [7:0]       frm_tos,
   output logic [7:0]       frm_icmp_type,
   output logic [7:0]       frm_icmp_code
);
   initial
   begin
      frm_valid = 1'b0;
      {frm_is_tcp, frm_is_icmp, frm_dport, frm_tcp_flags, frm_tos, frm_icmp_type, frm_icmp_code} = '0;
   end

   // fields are inverted after the valid cycle so stale values never match by luck
   task automatic send(input logic [47:0] h);
      frm_valid <= 1'b1;
      {frm_is_tcp, frm_is_icmp, frm_dport, frm_tcp_flags, frm_tos, frm_icmp_type, frm_icmp_code} <= h;
      @(posedge pclk);
      frm_valid <= 1'b0;
      {frm_is_tcp, frm_is_icmp, frm_dport, frm_tcp_flags, frm_tos, frm_icmp_type, frm_icmp_code} <= ~h;
   endtask : send
endmodule : l4m_parser_model
`default_nettype wire

// ==== bench/testbench.sv ====
// bench: l4 entry matcher checked against an integer model of the entry
// assumes: parser model beside it, apb master here, 20 MHz pclk
`timescale 1ns/1ps
`default_nettype none
module testbench
   import l4m_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, e;
   logic        frm_valid, frm_is_tcp, frm_is_icmp, res_valid, res_hit, res_pass, res_drop;
   logic [7:0]  paddr, frm_tos, frm_icmp_type, frm_icmp_code, f_tos, f_it, f_ic;
   logic [3:0]  pstrb;
   logic [15:0] frm_dport, f_dp;
   logic [5:0]  frm_tcp_flags, f_fl;
   logic        f_tcp, f_icmp;
   logic [31:0] pwdata, prdata, rd, c_ctrl, c_dp, c_fl, c_tos, c_ic, r;
   logic [31:0] x = 32'h0000_0039;
   int          error_cnt, n_tests, hits;
   int          lst[16] = '{0, 3, 4, 5, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 999};
   int          msk[8] = '{'h1ff, 'hffffffff, 'hfff, 'h7ff, 'hfffff, 0, 0, 0};
   int          dps[8] = '{0, 1, 99, 100, 200, 201, 65534, 65535};

   l4m_entry i_l4m_entry (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
      .prdata, .pslverr, .frm_valid, .frm_is_tcp, .frm_is_icmp, .frm_dport, .frm_tcp_flags, .frm_tos,
      .frm_icmp_type, .frm_icmp_code, .res_valid, .res_hit, .res_pass, .res_drop);
   l4m_parser_model i_parser (.pclk, .frm_valid, .frm_is_tcp, .frm_is_icmp, .frm_dport, .frm_tcp_flags,
      .frm_tos, .frm_icmp_type, .frm_icmp_code);

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   function automatic logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : rnd

   task automatic chk(input logic [31:0] s, input logic [31:0] w);
      n_tests++;
      if (s !== w)
      begin
         error_cnt++;
         $display("[ERR] %0t ns: seen %h want %h", $time, s, w);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   // one apb transfer, entered just after a rising edge, one idle edge at the end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // wait states end only at pready; a hang is left to the watchdog
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic cfg(input logic [31:0] c, d, f, t, i);
      c_ctrl = c & 32'h1ff;
      c_dp = d;
      c_fl = f & 32'hfff;
      c_tos = t & 32'h73f;
      c_ic = i & 32'hf_ffff;
      apb(1'b1, 8'h00, c, 4'hf);
      apb(1'b1, 8'h04, d, 4'hf);
      apb(1'b1, 8'h08, f, 4'hf);
      apb(1'b1, 8'h0c, t, 4'hf);
      apb(1'b1, 8'h10, i, 4'hf);
   endtask : cfg

   function automatic logic mdl();
      logic ok;
      ok = c_ctrl[0];
      case (c_ctrl[3:2])
         2'h1: ok &= f_dp == c_dp[15:0];
         2'h2: ok &= f_dp >= c_dp[15:0] && f_dp <= c_dp[31:16];
         2'h3: ok = 1'b0;
         default: ;
      endcase
      for (int i = 0; i < 6; i++)
         case (c_fl[2*i+:2])
            2'h1: ok &= f_tcp & f_fl[i];
            2'h2: ok &= f_tcp & ~f_fl[i];
            2'h3: ok = 1'b0;
            default: ;
         endcase
      case (c_ctrl[5:4])
         2'h1: ok &= f_tos[7:2] == c_tos[5:0];
         2'h2: ok &= f_tos[7:5] == c_tos[10:8];
         2'h3: ok = 1'b0;
         default: ;
      endcase
      case (c_ctrl[7:6])
         2'h1: ok &= f_icmp && f_it == lst[c_ic[19:16]];
         2'h2: ok &= f_icmp && f_it == c_ic[7:0];
         2'h3: ok = 1'b0;
         default: ;
      endcase
      if (c_ctrl[8])
         ok &= f_icmp && f_ic == c_ic[15:8];
      return ok;
   endfunction : mdl

   task automatic fr();
      e = mdl();
      i_parser.send({f_tcp, f_icmp, f_dp, f_fl, f_tos, f_it, f_ic});
      @(negedge pclk);
      chk(res_valid, 1'b1);
      chk(res_hit, e);
      chk(res_pass, e & ~c_ctrl[1]);
      chk(res_drop, e & c_ctrl[1]);
      hits += e;
      @(posedge pclk);
      apb(1'b0, 8'h14, 32'h0, 4'h0);
      chk(rd, {e & c_ctrl[1], e});
   endtask : fr

   initial
   begin
      #(50 * 60000);
      error_cnt++;
      close_out();
   end

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {f_tcp, f_icmp, f_dp, f_fl, f_tos, f_it, f_ic} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (msk[k])
      begin
         apb(1'b0, 8'(4 * k), 32'h0, 4'h0);
         chk(rd, 32'h0);
         chk(err, k == 7);
         apb(1'b1, 8'(4 * k), 32'hffff_ffff, 4'hf);
         apb(1'b0, 8'(4 * k), 32'h0, 4'h0);
         chk(rd, msk[k]);
      end
      apb(1'b1, 8'h04, 32'h0, 4'hc);
      apb(1'b0, 8'h04, 32'h0, 4'h0);
      chk(rd, 32'h0000_ffff);
      $display("register table done");
      for (int m = 0; m < 3; m++)
      begin
         cfg(m == 2 ? 32'h9 : 32'h5, m == 0 ? 32'hffff : m == 1 ? 32'h0 : 32'h00c8_0064, 0, 0, 0);
         foreach (dps[k])
         begin
            f_dp = 16'(dps[k]);
            fr();
         end
      end
      $display("dport done");
      for (int i = 0; i < 48; i++)
      begin
         cfg(32'h1, 0, (1 + i / 6 % 2) << (2 * (i % 6)), 0, 0);
         f_fl = 6'((i / 12 % 2) << (i % 6));
         f_tcp = i < 24;
         fr();
      end
      $display("tcp flags done");
      f_icmp = 1'b1;
      for (int i = 0; i < 32; i++)
      begin
         cfg(32'h41, 0, 0, 0, (i % 16) << 16);
         f_it = 8'(lst[i % 16] + i / 16);
         fr();
      end
      $display("icmp list done");
      for (int i = 0; i < 240; i++)
      begin
         if (i % 6 == 0)
            cfg(rnd() & rnd() & 32'h1fe | {31'h0, rnd() % 4 != 0}, rnd(), rnd() & rnd() & rnd() & rnd(),
               rnd(), rnd());
         r = rnd();
         {f_tcp, f_icmp} = r[1:0];
         f_dp = r[2] ? c_dp[r[3]*16+:16] : 16'(rnd());
         f_fl = 6'(rnd());
         f_tos = r[4] ? {c_tos[5:0], r[9:8]} : r[5] ? {c_tos[10:8], r[14:10]} : r[23:16];
         f_it = r[6] ? c_ic[7:0] : r[7] ? 8'(lst[c_ic[19:16]]) : r[31:24];
         f_ic = r[24] ? c_ic[15:8] : 8'(rnd());
         fr();
      end
      $display("random done");
      apb(1'b0, 8'h18, 32'h0, 4'h0);
      chk(rd, hits);
      apb(1'b1, 8'h18, 32'h0, 4'hf);
      apb(1'b0, 8'h18, 32'h0, 4'h0);
      chk(rd, 32'h0);
      // a hit in the clearing cycle must survive the clear
      cfg(32'h1, 0, 0, 0, 0);
      fork
         apb(1'b1, 8'h18, 32'h0, 4'hf);
         begin
            @(posedge pclk);
            i_parser.send({f_tcp, f_icmp, f_dp, f_fl, f_tos, f_it, f_ic});
         end
      join
      apb(1'b0, 8'h18, 32'h0, 4'h0);
      chk(rd, 32'h1);
      $display("hit counter done");
      close_out();
   end
endmodule : testbench
`default_nettype wire

// ==== src/l4m_defs.svh ====
// register offsets, field positions and reset values of the l4 entry matcher
// assumes: included by its bare name; definitions only
`ifndef L4M_DEFS_SVH
`define L4M_DEFS_SVH

// ==========================================================
// register byte offsets
`define L4M_OFF_CTRL      8'h00
`define L4M_OFF_DPORT     8'h04
`define L4M_OFF_FLAGS     8'h08
`define L4M_OFF_TOS       8'h0c
`define L4M_OFF_ICMP      8'h10
`define L4M_OFF_STAT      8'h14
`define L4M_OFF_HITS      8'h18

// ==========================================================
// field positions
`define L4M_CTRL_EN       0
`define L4M_CTRL_DENY     1
`define L4M_CTRL_DP_LSB   2
`define L4M_CTRL_TOS_LSB  4
`define L4M_CTRL_IT_LSB   6
`define L4M_CTRL_IC       8
`define L4M_DP_HI_LSB     16
`define L4M_TOS_PREC_LSB  8
`define L4M_ICMP_CODE_LSB 8
`define L4M_ICMP_IDX_LSB  16
`define L4M_DSCP_LSB      2
`define L4M_PREC_LSB      5

// ==========================================================
// reset values
`define L4M_RST_CTRL      9'h000
`define L4M_RST_DPORT     32'h0000_0000
`define L4M_RST_FLAGS     12'h000
`define L4M_RST_TOS       11'h000
`define L4M_RST_ICMP      20'h0_0000

`endif

// ==== src/l4m_entry.sv ====
// ipv4 access_entry layer-4 matcher with apb configuration registers
// assumes: frame fields come from the parser on pclk, valid for one cycle
`timescale 1ns/1ps
`default_nettype none
`include "l4m_defs.svh"

module l4m_entry
   import l4m_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        frm_valid,
   input  wire logic        frm_is_tcp,
   input  wire logic        frm_is_icmp,
   input  wire logic [15:0] frm_dport,
   input  wire logic [5:0]  frm_tcp_flags,
   input  wire logic [7:0]  frm_tos,
   input  wire logic [7:0]  frm_icmp_type,
   input  wire logic [7:0]  frm_icmp_code,
   output logic             res_valid,
   output logic             res_hit,
   output logic             res_pass,
   output logic             res_drop
);
   // =======================================================
   // declarations
   logic [8:0]  ctrl_r,  ctrl_nxt;
   logic [31:0] dport_r, dport_nxt;
   logic [11:0] flags_r, flags_nxt;
   logic [10:0] tos_r,   tos_nxt;
   logic [19:0] icmp_r,  icmp_nxt;
   logic [31:0] hits_r,  hits_nxt;
   logic [1:0]  stat_r,  stat_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic        valid_r, valid_nxt;
   logic        hit_r,   hit_nxt;
   logic        pass_r,  pass_nxt;
   logic        drop_r,  drop_nxt;
   logic        setup, wr_acc, addr_bad, hits_clr;
   logic [31:0] rd_val;
   logic        dp_ok, fl_ok, tos_ok, it_ok, ic_ok;
   logic [8:0]  named;
   logic [1:0]  dp_mode, tos_mode, it_mode;
   logic        deny;

   assign dp_mode  = ctrl_r[`L4M_CTRL_DP_LSB +: 2];
   assign tos_mode = ctrl_r[`L4M_CTRL_TOS_LSB +: 2];
   assign it_mode  = ctrl_r[`L4M_CTRL_IT_LSB +: 2];
   assign deny     = ctrl_r[`L4M_CTRL_DENY];

   // =======================================================
   // helpers
   function automatic logic [31:0] l4m_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
      logic [31:0] m;
      for (int b = 0; b < 4; b++)
         m[b*8 +: 8] = {8{st[b]}};
      return (old & ~m) | (wd & m);
   endfunction : l4m_merge

   // named icmp message types: {valid, type}
   function automatic logic [8:0] l4m_icmp_named(input logic [3:0] idx);
      case (idx)
         4'h0:    return 9'h100;
         4'h1:    return 9'h103;
         4'h2:    return 9'h104;
         4'h3:    return 9'h105;
         4'h4:    return 9'h108;
         4'h5:    return 9'h109;
         4'h6:    return 9'h10a;
         4'h7:    return 9'h10b;
         4'h8:    return 9'h10c;
         4'h9:    return 9'h10d;
         4'ha:    return 9'h10e;
         4'hb:    return 9'h10f;
         4'hc:    return 9'h110;
         4'hd:    return 9'h111;
         4'he:    return 9'h112;
         default: return 9'h000;
      endcase
   endfunction : l4m_icmp_named

   // =======================================================
   // apb slave
   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   always_comb
   begin
      setup       = psel & ~penable;
      wr_acc      = psel & penable & pwrite;
      ctrl_nxt    = ctrl_r;
      dport_nxt   = dport_r;
      flags_nxt   = flags_r;
      tos_nxt     = tos_r;
      icmp_nxt    = icmp_r;
      hits_clr    = 1'b0;
      rd_val      = 32'h0000_0000;
      addr_bad    = 1'b0;
      case (paddr)
         `L4M_OFF_CTRL:  rd_val = {23'h00_0000, ctrl_r};
         `L4M_OFF_DPORT: rd_val = dport_r;
         `L4M_OFF_FLAGS: rd_val = {20'h0_0000, flags_r};
         `L4M_OFF_TOS:   rd_val = {21'h00_0000, tos_r};
         `L4M_OFF_ICMP:  rd_val = {12'h000, icmp_r};
         `L4M_OFF_STAT:  rd_val = {30'h0000_0000, stat_r};
         `L4M_OFF_HITS:  rd_val = hits_r;
         default:        addr_bad = 1'b1;
      endcase
      if (wr_acc)
      begin
         case (paddr)
            `L4M_OFF_CTRL:  ctrl_nxt  = 9'(l4m_merge({23'h00_0000, ctrl_r}, pwdata, pstrb));
            `L4M_OFF_DPORT: dport_nxt = l4m_merge(dport_r, pwdata, pstrb);
            `L4M_OFF_FLAGS: flags_nxt = 12'(l4m_merge({20'h0_0000, flags_r}, pwdata, pstrb));
            `L4M_OFF_TOS:   tos_nxt   = 11'(l4m_merge({21'h00_0000, tos_r}, pwdata, pstrb));
            `L4M_OFF_ICMP:  icmp_nxt  = 20'(l4m_merge({12'h000, icmp_r}, pwdata, pstrb));
            `L4M_OFF_HITS:  hits_clr  = 1'b1;
            default:        hits_clr  = 1'b0;
         endcase
      end
      prdata_nxt  = setup ? (pwrite ? 32'h0000_0000 : rd_val) : prdata_r;
      pslverr_nxt = setup ? addr_bad : pslverr_r;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r    <= `L4M_RST_CTRL;
         dport_r   <= `L4M_RST_DPORT;
         flags_r   <= `L4M_RST_FLAGS;
         tos_r     <= `L4M_RST_TOS;
         icmp_r    <= `L4M_RST_ICMP;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         ctrl_r    <= ctrl_nxt;
         dport_r   <= dport_nxt;
         flags_r   <= flags_nxt;
         tos_r     <= tos_nxt;
         icmp_r    <= icmp_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // =======================================================
   // criteria
   l4m_port_cmp u_dport
   (
      .mode (dp_mode),
      .port (frm_dport),
      .lo   (dport_r[15:0]),
      .hi   (dport_r[`L4M_DP_HI_LSB +: 16]),
      .ok   (dp_ok)
   );

   l4m_flag_match #(.N(6)) u_flags
   (
      .crit   (flags_r),
      .flags  (frm_tcp_flags),
      .is_tcp (frm_is_tcp),
      .ok     (fl_ok)
   );

   always_comb
   begin
      named = l4m_icmp_named(icmp_r[`L4M_ICMP_IDX_LSB +: 4]);
      unique case (tos_mode)
         L4M_TOS_ANY:  tos_ok = 1'b1;
         L4M_TOS_DSCP: tos_ok = (frm_tos[`L4M_DSCP_LSB +: 6] == tos_r[5:0]);
         L4M_TOS_PREC: tos_ok = (frm_tos[`L4M_PREC_LSB +: 3] == tos_r[`L4M_TOS_PREC_LSB +: 3]);
         default:      tos_ok = 1'b0;
      endcase
      // icmp criteria need an icmp frame
      unique case (it_mode)
         L4M_IT_ANY:  it_ok = 1'b1;
         L4M_IT_LIST: it_ok = frm_is_icmp && (named == {1'b1, frm_icmp_type});
         L4M_IT_NUM:  it_ok = frm_is_icmp && (frm_icmp_type == icmp_r[7:0]);
         default:     it_ok = 1'b0;
      endcase
      ic_ok = !ctrl_r[`L4M_CTRL_IC] ||
              (frm_is_icmp && (frm_icmp_code == icmp_r[`L4M_ICMP_CODE_LSB +: 8]));
   end

   // =======================================================
   // verdict and counters
   always_comb
   begin
      valid_nxt = frm_valid;
      hit_nxt   = frm_valid & ctrl_r[`L4M_CTRL_EN] & dp_ok & fl_ok & tos_ok & it_ok & ic_ok;
      pass_nxt  = hit_nxt & ~deny;
      drop_nxt  = hit_nxt & deny;
      stat_nxt  = frm_valid ? {drop_nxt, hit_nxt} : stat_r;
      // a hit in the clearing cycle is added after the clear, so the count restarts at one
      hits_nxt  = (hits_clr ? 32'h0000_0000 : hits_r) + {31'h0000_0000, hit_nxt};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         valid_r <= 1'b0;
         hit_r   <= 1'b0;
         pass_r  <= 1'b0;
         drop_r  <= 1'b0;
         stat_r  <= 2'h0;
         hits_r  <= 32'h0000_0000;
      end
      else
      begin
         valid_r <= valid_nxt;
         hit_r   <= hit_nxt;
         pass_r  <= pass_nxt;
         drop_r  <= drop_nxt;
         stat_r  <= stat_nxt;
         hits_r  <= hits_nxt;
      end
   end

   assign res_valid = valid_r;
   assign res_hit   = hit_r;
   assign res_pass  = pass_r;
   assign res_drop  = drop_r;

   // =======================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_all_dontcare_hit: assert property (
      frm_valid && ctrl_r[`L4M_CTRL_EN] && dp_mode == L4M_DP_ANY && flags_r == 12'h000 &&
      tos_mode == L4M_TOS_ANY && it_mode == L4M_IT_ANY && !ctrl_r[`L4M_CTRL_IC] |=> res_hit)
      else $error("all dontcare frame missed");
   a_dport_single_ne: assert property (
      frm_valid && dp_mode == L4M_DP_SINGLE && frm_dport != dport_r[15:0] |=> !res_hit)
      else $error("single dport mismatch hit");
   a_dport_range_out: assert property (
      frm_valid && dp_mode == L4M_DP_RANGE &&
      (frm_dport < dport_r[15:0] || frm_dport > dport_r[31:16]) |=> !res_hit)
      else $error("port outside range hit");
   for (genvar i = 0; i < 6; i++)
   begin : g_flag_chk
      a_flag_crit_bad: assert property (
         frm_valid && ((flags_r[2*i +: 2] == L4M_FL_SET && !frm_tcp_flags[i]) ||
         (flags_r[2*i +: 2] == L4M_FL_UNSET && frm_tcp_flags[i])) |=> !res_hit)
         else $error("tcp flag criterion violated");
   end
   a_dscp_ne: assert property (
      frm_valid && tos_mode == L4M_TOS_DSCP && frm_tos[7:2] != tos_r[5:0] |=> !res_hit)
      else $error("dscp mismatch hit");
   a_prec_ne: assert property (
      frm_valid && tos_mode == L4M_TOS_PREC && frm_tos[7:5] != tos_r[10:8] |=> !res_hit)
      else $error("precedence mismatch hit");
   a_icmp_named_ne: assert property (
      frm_valid && it_mode == L4M_IT_LIST && named != {1'b1, frm_icmp_type} |=> !res_hit)
      else $error("named icmp type mismatch hit");
   a_icmp_type_ne: assert property (
      frm_valid && it_mode == L4M_IT_NUM && frm_icmp_type != icmp_r[7:0] |=> !res_hit)
      else $error("icmp type mismatch hit");
   a_icmp_code_ne: assert property (
      frm_valid && ctrl_r[`L4M_CTRL_IC] && frm_icmp_code != icmp_r[15:8] |=> !res_hit)
      else $error("icmp code mismatch hit");
   a_permit_pass: assert property (
      res_valid |-> res_pass == (res_hit && !$past(deny)))
      else $error("permit verdict wrong");
   a_deny_drop: assert property (
      res_valid |-> res_drop == (res_hit && $past(deny)) && !(res_drop && res_pass))
      else $error("deny verdict wrong");
   a_hit_needs_en: assert property (
      res_hit |-> $past(frm_valid) && $past(ctrl_r[`L4M_CTRL_EN]) && res_valid)
      else $error("hit without enabled frame");
   a_wrong_proto: assert property (
      frm_valid && ((!frm_is_tcp && flags_r != 12'h000) ||
      (!frm_is_icmp && (it_mode != L4M_IT_ANY || ctrl_r[`L4M_CTRL_IC]))) |=> !res_hit)
      else $error("wrong protocol frame hit");
   a_dport_single_eq: assert property (
      frm_valid && ctrl_r[`L4M_CTRL_EN] && dp_mode == L4M_DP_SINGLE && frm_dport == dport_r[15:0] &&
      fl_ok && tos_ok && it_ok && ic_ok |=> res_hit)
      else $error("single dport match missed");
   a_dport_range_in: assert property (
      frm_valid && ctrl_r[`L4M_CTRL_EN] && dp_mode == L4M_DP_RANGE && frm_dport >= dport_r[15:0] &&
      frm_dport <= dport_r[31:16] && fl_ok && tos_ok && it_ok && ic_ok |=> res_hit)
      else $error("port inside range missed");
   a_tos_any_pass: assert property (
      frm_valid && ctrl_r[`L4M_CTRL_EN] && tos_mode == L4M_TOS_ANY && dp_ok && fl_ok && it_ok && ic_ok
      |=> res_hit)
      else $error("tos any vetoed a frame");
   a_type_any_pass: assert property (
      frm_valid && ctrl_r[`L4M_CTRL_EN] && it_mode == L4M_IT_ANY && dp_ok && fl_ok && tos_ok && ic_ok
      |=> res_hit)
      else $error("icmp type any vetoed a frame");
   a_code_any_pass: assert property (
      frm_valid && ctrl_r[`L4M_CTRL_EN] && !ctrl_r[`L4M_CTRL_IC] && dp_ok && fl_ok && tos_ok && it_ok
      |=> res_hit)
      else $error("icmp code any vetoed a frame");
   a_res_quiet_idle: assert property (
      !res_valid |-> !res_hit && !res_pass && !res_drop)
      else $error("verdict outside result cycle");
   a_stat_follows: assert property (
      res_valid |-> stat_r == {res_drop, res_hit})
      else $error("status differs from verdict");
   a_hits_clear_hit: assert property (
      hits_clr && hit_nxt |=> hits_r == 32'h0000_0001)
      else $error("hit lost against counter clear");

   c_permit_hit: cover property (res_pass);
   c_deny_hit:   cover property (res_drop);
   c_range_hit:  cover property (frm_valid && dp_mode == L4M_DP_RANGE ##1 res_hit);
   c_named_hit:  cover property (frm_valid && it_mode == L4M_IT_LIST ##1 res_hit);
   c_clear_hit:  cover property (hits_clr && hit_nxt);
endmodule : l4m_entry
`default_nettype wire

// ==== src/l4m_flag_match.sv ====
// three-state tcp flag criteria, one per flag bit
// assumes: flags[0] fin .. flags[5] urg; combinational
`timescale 1ns/1ps
`default_nettype none
module l4m_flag_match
   import l4m_pkg::*;
#(
   parameter int N = 6
)
(
   input  wire logic [2*N-1:0] crit,
   input  wire logic [N-1:0]   flags,
   input  wire logic           is_tcp,
   output logic                ok
);
   logic [N-1:0] bit_ok;

   for (genvar i = 0; i < N; i++)
   begin : g_flag
      assign bit_ok[i] = (crit[2*i +: 2] == L4M_FL_DC) ||
                         (is_tcp && (crit[2*i +: 2] == L4M_FL_SET) && flags[i]) ||
                         (is_tcp && (crit[2*i +: 2] == L4M_FL_UNSET) && !flags[i]);
   end

   assign ok = &bit_ok;
endmodule : l4m_flag_match
`default_nettype wire

// ==== src/l4m_pkg.sv ====
// mode and criterion encodings of the l4 entry matcher
// assumes: compiled before every module that imports it
package l4m_pkg;
   typedef enum logic [1:0] {L4M_DP_ANY = 2'h0, L4M_DP_SINGLE = 2'h1, L4M_DP_RANGE = 2'h2} l4m_dp_mode_t;
   typedef enum logic [1:0] {L4M_TOS_ANY = 2'h0, L4M_TOS_DSCP = 2'h1, L4M_TOS_PREC = 2'h2} l4m_tos_mode_t;
   typedef enum logic [1:0] {L4M_IT_ANY = 2'h0, L4M_IT_LIST = 2'h1, L4M_IT_NUM = 2'h2} l4m_it_mode_t;
   typedef enum logic [1:0] {L4M_FL_DC = 2'h0, L4M_FL_SET = 2'h1, L4M_FL_UNSET = 2'h2} l4m_flag_crit_t;
endpackage : l4m_pkg

// ==== src/l4m_port_cmp.sv ====
// destination port criterion: any, single value or inclusive range
// assumes: purely combinational, inputs from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module l4m_port_cmp
   import l4m_pkg::*;
(
   input  wire logic [1:0]  mode,
   input  wire logic [15:0] port,
   input  wire logic [15:0] lo,
   input  wire logic [15:0] hi,
   output logic             ok
);
   always_comb
   begin
      unique case (mode)
         L4M_DP_ANY:    ok = 1'b1;
         L4M_DP_SINGLE: ok = (port == lo);
         L4M_DP_RANGE:  ok = (port >= lo) && (port <= hi);
         default:       ok = 1'b0;
      endcase
   end
endmodule : l4m_port_cmp
`default_nettype wire
